// File: src/spe_engine.sv
// Serial program port engine: link sequencer, register file, flash start.
// Assumes the programming clock is far slower than CLOCK (two-flop sampled).
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module spe_engine
  import spe_pkg::*;
(
  // System clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // Avalon-MM slave
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Programming link pins
  input  wire logic        PROG_CLOCK_PIN,
  input  wire logic        PROG_DATA_PIN_I,
  output var  logic        PROG_DATA_PIN_O,
  output var  logic        PROG_DATA_PIN_OE,
  // CPU core side
  output var  spe_exec_s   EXEC,
  output logic             CPU_SUSPEND,
  output var  logic        CPU_RESET_REQ,
  // Flash controller side
  output var  spe_flash_s  FLASH
);

  logic        clk_sync;      // Synchronised programming clock
  logic        dat_sync;      // Synchronised data pin
  logic        clk_prev_ff;   // Previous clock level
  logic        rise_ev;       // Programming clock rising edge
  logic        fall_ev;       // Programming clock falling edge
  spe_state_e  state_ff;      // Link sequencer state
  logic [4:0]  bit_cnt_ff;    // Bits or cycles in current phase
  logic [3:0]  code_sr_ff;    // Control code shifter
  logic [3:0]  nxt_code;      // Code including the current bit
  logic [23:0] instr_sr_ff;   // Instruction shifter
  logic [23:0] nxt_instr;     // Instruction including current bit
  logic [2:0]  exec_cnt_ff;   // Remaining execute cycles
  logic [15:0] out_sr_ff;     // Visible register shift-out copy
  logic        out_live_ff;   // A bit has been presented
  logic [15:0] mem_ctrl_ff;   // Memory control register
  logic [15:0] visible_ff;    // Visible output register
  logic [23:0] pc_ff;         // Program counter
  logic        pc_bad;        // Counter in an invalid region
  logic        pc_bad_ff;     // Previous invalid flag
  logic [1:0]  key_ff;        // Unlock progress: 0 none, 1 first, 2 armed
  logic [7:0]  op_cnt_ff;     // Remaining operation clocks
  logic        ack_ff;        // Bus answer cycle
  logic        bus_req;       // Read or write pending
  logic        wr_take;       // Write takes effect this cycle
  logic [31:0] rd_mux;        // Read data selection
  logic [15:0] mc_wdata;      // Memory control write, lanes merged
  logic        op_legal;      // Written operation is known
  logic [7:0]  op_len;        // Length of the written operation

  // Both pins see the same two-flop delay, so skew is preserved
  spe_pin_sync u_clk_sync
  (
    .CLOCK (CLOCK),
    .RESET (RESET),
    .PIN   (PROG_CLOCK_PIN),
    .SYNC  (clk_sync)
  );

  spe_pin_sync u_dat_sync
  (
    .CLOCK (CLOCK),
    .RESET (RESET),
    .PIN   (PROG_DATA_PIN_I),
    .SYNC  (dat_sync)
  );

  // Edge detection on the synchronised clock
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      clk_prev_ff <= 1'b0;
    else
      clk_prev_ff <= clk_sync;
  end

  assign rise_ev = clk_sync & ~clk_prev_ff;
  assign fall_ev = ~clk_sync & clk_prev_ff;

  // Shifters take the new bit at the top: low bit arrives first
  assign nxt_code  = {dat_sync, code_sr_ff[3:1]};
  assign nxt_instr = {dat_sync, instr_sr_ff[23:1]};

  // Link sequencer: codes, instruction shift, register shift-out
  always_ff @(posedge CLOCK)
  begin
    if (RESET || CPU_RESET_REQ)
    begin
      state_ff   <= SPE_ST_CODE;
      bit_cnt_ff <= 5'h00;
    end
    else if (rise_ev)
    begin
      unique case (state_ff)
        SPE_ST_CODE:
        begin
          if (bit_cnt_ff == SPE_CODE_BITS_LAST)
          begin
            bit_cnt_ff <= 5'h00;
            if (nxt_code == SPE_CODE_SERIAL_EXECUTE)
              state_ff <= SPE_ST_SIX_IN;
            else if (nxt_code == SPE_CODE_REG_SHIFT_OUT)
              state_ff <= SPE_ST_REG_IDLE;
            else
              state_ff <= SPE_ST_CODE;
          end
          else
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
        SPE_ST_SIX_IN:
        begin
          // Back to code reception while the word executes
          if (bit_cnt_ff == SPE_INSTR_BITS_LAST)
          begin
            bit_cnt_ff <= 5'h00;
            state_ff   <= SPE_ST_CODE;
          end
          else
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
        SPE_ST_REG_IDLE:
        begin
          if (bit_cnt_ff == SPE_REG_IDLE_LAST)
          begin
            bit_cnt_ff <= 5'h00;
            state_ff   <= SPE_ST_REG_OUT;
          end
          else
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
        SPE_ST_REG_OUT:
        begin
          // Count only edges that captured a presented bit
          if (out_live_ff)
          begin
            if (bit_cnt_ff == SPE_REG_OUT_LAST)
            begin
              bit_cnt_ff <= 5'h00;
              state_ff   <= SPE_ST_REG_HOLD;
            end
            else
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
        end
        SPE_ST_REG_HOLD:
        begin
          state_ff   <= SPE_ST_CODE;
          bit_cnt_ff <= 5'h00;
        end
        default:
        begin
          state_ff   <= SPE_ST_CODE;
          bit_cnt_ff <= 5'h00;
        end
      endcase
    end
  end

  // Control code and instruction shifters
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      code_sr_ff  <= 4'h0;
      instr_sr_ff <= 24'h000000;
    end
    else if (rise_ev)
    begin
      if (state_ff == SPE_ST_CODE)
        code_sr_ff <= nxt_code;
      if (state_ff == SPE_ST_SIX_IN)
        instr_sr_ff <= nxt_instr;
    end
  end

  // Hand the word to the CPU and time its execute window
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      EXEC        <= '0;
      exec_cnt_ff <= 3'h0;
    end
    else
    begin
      EXEC.valid <= 1'b0;
      if (rise_ev && state_ff == SPE_ST_SIX_IN && bit_cnt_ff == SPE_INSTR_BITS_LAST)
      begin
        EXEC.valid   <= 1'b1;
        EXEC.instr   <= nxt_instr;
        EXEC.running <= 1'b1;
        exec_cnt_ff  <= SPE_EXEC_CYCLES;
      end
      else if (rise_ev && exec_cnt_ff != 3'h0)
      begin
        // Window closes after four programming clocks
        exec_cnt_ff  <= exec_cnt_ff - 3'h1;
        EXEC.running <= (exec_cnt_ff != 3'h1);
      end
    end
  end

  // CPU sits still while a word is shifted or before shift-out
  assign CPU_SUSPEND = (state_ff == SPE_ST_SIX_IN) || (state_ff == SPE_ST_REG_IDLE);

  // Data pin driver: bits change on falling edges only
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      PROG_DATA_PIN_O  <= 1'b0;
      PROG_DATA_PIN_OE <= 1'b0;
      out_sr_ff        <= 16'h0000;
      out_live_ff      <= 1'b0;
    end
    else
    begin
      if (rise_ev && state_ff == SPE_ST_REG_IDLE && bit_cnt_ff == SPE_REG_IDLE_LAST)
      begin
        // Snapshot so a CPU write cannot tear the word
        out_sr_ff   <= visible_ff;
        out_live_ff <= 1'b0;
      end
      else if (fall_ev && state_ff == SPE_ST_REG_OUT)
      begin
        PROG_DATA_PIN_OE <= 1'b1;
        PROG_DATA_PIN_O  <= out_sr_ff[0];
        out_sr_ff        <= {1'b0, out_sr_ff[15:1]};
        out_live_ff      <= 1'b1;
      end
      else if (rise_ev && state_ff == SPE_ST_REG_HOLD)
      begin
        PROG_DATA_PIN_OE <= 1'b0;
        out_live_ff      <= 1'b0;
      end
    end
  end

  // Counter checks: vector space or beyond implemented flash
  assign pc_bad = (pc_ff <= SPE_PC_VECTOR_TOP) || (pc_ff > SPE_PC_FLASH_TOP);

  // Program counter: advances per executed word, loaded by a jump
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pc_ff         <= SPE_PC_SAFE;
      pc_bad_ff     <= 1'b0;
      CPU_RESET_REQ <= 1'b0;
    end
    else
    begin
      pc_bad_ff     <= pc_bad;
      // Pulse once on entry, not every cycle spent there
      CPU_RESET_REQ <= pc_bad & ~pc_bad_ff;
      if (wr_take && AVS_ADDRESS == SPE_OFS_PROG_COUNTER)
        pc_ff <= AVS_WRITEDATA[23:0];
      else if (EXEC.valid)
        pc_ff <= pc_ff + SPE_PC_STEP;
    end
  end

  // Avalon: every access answers on its second cycle
  assign bus_req         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req & ~ack_ff;
  assign wr_take         = AVS_WRITE & ack_ff;

  // Byte-lane merge and operation decode for memory control
  always_comb
  begin
    mc_wdata[7:0]  = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0]  : mem_ctrl_ff[7:0];
    mc_wdata[15:8] = AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : mem_ctrl_ff[15:8];
    op_legal = 1'b1;
    op_len   = SPE_DWORD_PROG_CYC;
    unique case (mc_wdata & SPE_MC_WRITE_MASK)
      SPE_OP_BULK_ERASE:    op_len = SPE_BULK_ERASE_CYC;
      SPE_OP_PAGE_ERASE:    op_len = SPE_PAGE_ERASE_CYC;
      SPE_OP_DWORD_PROGRAM: op_len = SPE_DWORD_PROG_CYC;
      default:              op_legal = 1'b0;
    endcase
  end

  // Bus answer and read data, registered
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      ack_ff       <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end
    else
    begin
      ack_ff <= bus_req & ~ack_ff;
      if (AVS_READ && !ack_ff)
        AVS_READDATA <= rd_mux;
    end
  end

  // Read selection; unmapped offsets read zero
  always_comb
  begin
    unique case (AVS_ADDRESS)
      SPE_OFS_MEM_CTRL:     rd_mux = {16'h0000, mem_ctrl_ff};
      SPE_OFS_UNLOCK_KEY:   rd_mux = {30'h00000000, key_ff};
      SPE_OFS_VISIBLE_OUT:  rd_mux = {16'h0000, visible_ff};
      SPE_OFS_INSTR:        rd_mux = {8'h00, EXEC.instr};
      SPE_OFS_PROG_COUNTER: rd_mux = {8'h00, pc_ff};
      SPE_OFS_STATUS:       rd_mux = {24'h000000, FLASH.busy, EXEC.running, 1'b0, state_ff};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // Visible output register, written by the CPU core
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      visible_ff <= SPE_VIS_RESET;
    else if (wr_take && AVS_ADDRESS == SPE_OFS_VISIBLE_OUT)
    begin
      if (AVS_BYTEENABLE[0])
        visible_ff[7:0] <= AVS_WRITEDATA[7:0];
      if (AVS_BYTEENABLE[1])
        visible_ff[15:8] <= AVS_WRITEDATA[15:8];
    end
  end

  // Unlock key tracking: any other key value or a memory control write disarms
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      key_ff <= 2'h0;
    else if (wr_take && AVS_ADDRESS == SPE_OFS_UNLOCK_KEY)
    begin
      if (AVS_WRITEDATA[7:0] == SPE_KEY_FIRST)
        key_ff <= 2'h1;
      else if (AVS_WRITEDATA[7:0] == SPE_KEY_SECOND && key_ff == 2'h1)
        key_ff <= 2'h2;
      else
        key_ff <= 2'h0;
    end
    else if (wr_take && AVS_ADDRESS == SPE_OFS_MEM_CTRL)
      key_ff <= 2'h0;                                     // Key is single-use
  end

  // Memory control and operation timer on programming clocks
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      mem_ctrl_ff <= SPE_MC_RESET;
      op_cnt_ff   <= 8'h00;
      FLASH       <= '0;
    end
    else if (wr_take && AVS_ADDRESS == SPE_OFS_MEM_CTRL && !FLASH.busy)
    begin
      // Fields are frozen while an operation runs
      mem_ctrl_ff[14:0] <= mc_wdata[14:0] & SPE_MC_WRITE_MASK[14:0];
      mem_ctrl_ff[SPE_MC_START_BIT] <= 1'b0;
      if (mc_wdata[SPE_MC_START_BIT])
      begin
        if (key_ff == 2'h2 && op_legal && mc_wdata[SPE_MC_ENABLE_BIT])
        begin
          mem_ctrl_ff[SPE_MC_START_BIT] <= 1'b1;
          mem_ctrl_ff[SPE_MC_ERROR_BIT] <= 1'b0;
          op_cnt_ff  <= op_len;
          FLASH.busy <= 1'b1;
          FLASH.op   <= mc_wdata[3:0];
        end
        else
          mem_ctrl_ff[SPE_MC_ERROR_BIT] <= 1'b1;
      end
    end
    else if (FLASH.busy && rise_ev)
    begin
      // Only programming clock edges advance the operation
      if (op_cnt_ff == 8'h01)
      begin
        op_cnt_ff  <= 8'h00;
        FLASH.busy <= 1'b0;
        mem_ctrl_ff[SPE_MC_START_BIT] <= 1'b0;
      end
      else
        op_cnt_ff <= op_cnt_ff - 8'h01;
    end
  end

endmodule
`default_nettype wire

// File: src/spe_pin_sync.sv
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin is quasi-static relative to the system clock.
`timescale 1ns/1ns
`default_nettype none
module spe_pin_sync
  import spe_pkg::*;
(
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RESET,
  // Pin in, synchronised level out
  input  wire logic PIN,
  output var  logic SYNC
);

  logic meta_ff; // First stage, read only by second

  // Two flops; first stage feeds nothing else
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      meta_ff <= 1'b0;
      SYNC    <= 1'b0;
    end
    else
    begin
      meta_ff <= PIN;
      SYNC    <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// File: src/spe_pkg.sv
// Constants and carrier types for the serial program port engine.
// Assumes a 50 MHz system clock and a slow external programming clock.
// Function
// - 0000 executes instruction, 0001 shifts out register
// - Programming clock drives shifting and CPU execution
// - CPU suspended 24 clocks during instruction shift
// - Shifted instruction executes over next four clocks
// - Next control code shifts in during execution
// - Data pin sampled on programming clock rising edge
// - No automatic stall; programmer inserts no-op
// - Counter advances; bad address triggers device reset
// - Register shift-out: 8 idle, 16 output clocks
// - Data pin turns output after shift-out code
// - Drive pin until next rising edge, then release
// - Data changes on falling, captured on rising
// - All transfers send least significant bit first
// - Write-start bit 15 launches selected operation
// - Hardware clears write-start bit on completion
// - 400Eh bulk erase, 4003h page erase
// - 4001h selects double-word programming
// - Key 55h then AAh required before start
package spe_pkg;

  // Link control codes, 4 bits, sent low bit first
  localparam logic [3:0]  SPE_CODE_SERIAL_EXECUTE = 4'h0;
  localparam logic [3:0]  SPE_CODE_REG_SHIFT_OUT  = 4'h1;

  // Shift lengths and phase counts in programming clock cycles
  localparam logic [4:0]  SPE_CODE_BITS_LAST   = 5'h03;
  localparam logic [4:0]  SPE_INSTR_BITS_LAST  = 5'h17;
  localparam logic [2:0]  SPE_EXEC_CYCLES      = 3'h4;
  localparam logic [4:0]  SPE_REG_IDLE_LAST    = 5'h07;
  localparam logic [4:0]  SPE_REG_OUT_LAST     = 5'h0F;

  // Register byte offsets on the Avalon slave
  localparam logic [5:0]  SPE_OFS_MEM_CTRL     = 6'h00;
  localparam logic [5:0]  SPE_OFS_UNLOCK_KEY   = 6'h04;
  localparam logic [5:0]  SPE_OFS_VISIBLE_OUT  = 6'h08;
  localparam logic [5:0]  SPE_OFS_INSTR        = 6'h0C;
  localparam logic [5:0]  SPE_OFS_PROG_COUNTER = 6'h10;
  localparam logic [5:0]  SPE_OFS_STATUS       = 6'h14;

  // Memory control field positions
  localparam int          SPE_MC_START_BIT     = 15;
  localparam int          SPE_MC_ENABLE_BIT    = 14;
  localparam int          SPE_MC_ERROR_BIT     = 13;
  localparam logic [15:0] SPE_MC_WRITE_MASK    = 16'h400F;

  // Operation select values, start bit clear
  localparam logic [15:0] SPE_OP_BULK_ERASE    = 16'h400E;
  localparam logic [15:0] SPE_OP_PAGE_ERASE    = 16'h4003;
  localparam logic [15:0] SPE_OP_DWORD_PROGRAM = 16'h4001;

  // Unlock key values
  localparam logic [7:0]  SPE_KEY_FIRST        = 8'h55;
  localparam logic [7:0]  SPE_KEY_SECOND       = 8'hAA;

  // Operation lengths in programming clock rising edges
  localparam logic [7:0]  SPE_BULK_ERASE_CYC   = 8'hC0;
  localparam logic [7:0]  SPE_PAGE_ERASE_CYC   = 8'h60;
  localparam logic [7:0]  SPE_DWORD_PROG_CYC   = 8'h20;

  // Program counter limits and reset values
  localparam logic [23:0] SPE_PC_SAFE          = 24'h000200;
  localparam logic [23:0] SPE_PC_VECTOR_TOP    = 24'h0001FF;
  localparam logic [23:0] SPE_PC_FLASH_TOP     = 24'h02AFFE;
  localparam logic [23:0] SPE_PC_STEP          = 24'h000002;
  localparam logic [15:0] SPE_MC_RESET         = 16'h0000;
  localparam logic [15:0] SPE_VIS_RESET        = 16'h0000;

  // Link sequencer states, one-hot
  typedef enum logic [4:0] {
    SPE_ST_CODE     = 5'b00001,
    SPE_ST_SIX_IN   = 5'b00010,
    SPE_ST_REG_IDLE = 5'b00100,
    SPE_ST_REG_OUT  = 5'b01000,
    SPE_ST_REG_HOLD = 5'b10000
  } spe_state_e;

  // Instruction handed to the CPU core
  typedef struct packed {
    logic        valid;   // One-cycle pulse, word ready
    logic        running; // Level during the execute window
    logic [23:0] instr;   // Instruction word
  } spe_exec_s;

  // Flash controller request
  typedef struct packed {
    logic       busy;     // Level while operation runs
    logic [3:0] op;       // Selected operation code
  } spe_flash_s;

endpackage

// File: tb/spe_engine_props.sv
// Checker for the serial program port engine, bound to its top ports.
// Assumes the link clock idles low through reset.
`timescale 1ns/1ns
`default_nettype none
module spe_engine_props
  import spe_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Register bus
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_READ,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic        AVS_WAITREQUEST,
  // Link and core side
  input wire logic        PROG_CLOCK_PIN,
  input wire logic        PROG_DATA_PIN_O,
  input wire logic        PROG_DATA_PIN_OE,
  input wire spe_exec_s   EXEC,
  input wire logic        CPU_SUSPEND,
  input wire logic        CPU_RESET_REQ,
  input wire spe_flash_s  FLASH
);
  logic [2:0] sync_ff;    // Meta, level, previous level of link clock
  logic [2:0] run_len_ff; // Link rises in the execute window
  logic       start_ff;   // A start write was taken last cycle
  wire        pclk_hi = sync_ff[1];
  wire        pclk_up = sync_ff[1] & ~sync_ff[2];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Same depth as the engine's sampler, so edges line up
  always_ff @(posedge CLOCK)
    sync_ff <= {sync_ff[1:0], PROG_CLOCK_PIN};
  // Rises, not cycles: a stalled link clock stretches the window
  always_ff @(posedge CLOCK)
    run_len_ff <= EXEC.valid ? 3'h0 : run_len_ff + {2'h0, EXEC.running & pclk_up};
  // Start request seen at the bus
  always_ff @(posedge CLOCK)
    start_ff <= AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == SPE_OFS_MEM_CTRL
                && AVS_WRITEDATA[SPE_MC_START_BIT];

  a_wait_once: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1
                                !AVS_WAITREQUEST)
    else $error("bus wait not one cycle");
  a_valid_pulse: assert property (EXEC.valid |=> !EXEC.valid)
    else $error("valid too long");
  a_run_four: assert property ($fell(EXEC.running) |-> run_len_ff == 3'h4)
    else $error("window not four link clocks");
  a_suspend_end: assert property (EXEC.valid |-> ##[0:1] !CPU_SUSPEND)
    else $error("suspend after word taken");
  a_oe_rise_low: assert property ($rose(PROG_DATA_PIN_OE) |-> !pclk_hi)
    else $error("output enable off a falling edge");
  a_oe_drop_high: assert property ($fell(PROG_DATA_PIN_OE) |-> pclk_hi)
    else $error("pin released early");
  a_data_steady: assert property (PROG_DATA_PIN_OE && pclk_hi && $past(pclk_hi) |->
                                  $stable(PROG_DATA_PIN_O))
    else $error("data moved while link clock high");
  a_no_drive_idle: assert property (CPU_SUSPEND |-> !PROG_DATA_PIN_OE)
    else $error("pin driven in suspend");
  a_start_cause: assert property ($rose(FLASH.busy) |-> start_ff)
    else $error("flash start without start write");
  a_busy_on_edge: assert property ($fell(FLASH.busy) |-> pclk_hi)
    else $error("flash end off a link edge");
  a_req_pulse: assert property (CPU_RESET_REQ |=> !CPU_RESET_REQ)
    else $error("reset request too long");
endmodule

bind spe_engine spe_engine_props u_props (.CLOCK, .RESET, .AVS_ADDRESS, .AVS_WRITE,
  .AVS_READ, .AVS_WRITEDATA, .AVS_WAITREQUEST, .PROG_CLOCK_PIN, .PROG_DATA_PIN_O,
  .PROG_DATA_PIN_OE, .EXEC, .CPU_SUSPEND, .CPU_RESET_REQ, .FLASH);
`default_nettype wire

// File: tb/spe_prog_model.sv
// External programmer model: drives the link clock and data pin.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/1ns
`default_nettype none
module spe_prog_model (
  // Pacing clock
  input  wire logic clock,
  // Link side
  output var  logic pclk,
  output var  logic pdata,
  output var  logic poe,
  input  wire logic pin
);
  localparam int HALF = 4; // System clocks per half link period

  // Clock idles low, pin driven low
  initial
  begin
    pclk  = 1'h0;
    pdata = 1'h0;
    poe   = 1'h1;
  end

  // Move n bits LSB first; drive low frees the pin.
  // Clock idles high between calls.
  task automatic xfer(input logic [23:0] v, input int n, input logic drive,
                      output logic [23:0] got);
    got = 24'h000000;
    for (int i = 0; i < n; i++)
    begin
      pclk  <= 1'h0;  // Data moves on the falling edge
      pdata <= v[i];
      poe   <= drive;
      repeat (HALF) @(posedge clock);
      got[i] = pin;   // Engine bit settled
      pclk  <= 1'h1;  // Engine samples here
      repeat (HALF) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_serial_program_port_engine.sv
// Self-checking bench for the serial program port engine.
// Assumes the programmer model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_program_port_engine
  import spe_pkg::*;
;
  logic        clock = 1'h0;  // 50 MHz
  logic        reset = 1'h1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pclk, pdata, poe, dout, doe;
  logic        float_ff = 1'h0; // Undriven wire wanders every cycle
  spe_exec_s   exec;
  spe_flash_s  flash;
  logic        cpu_suspend, cpu_reset_req;
  logic [31:0] rd;
  logic [23:0] got, last_instr;
  int          bad_count = 0, n_compared = 0, cycles = 0, valid_seen = 0, req_seen = 0;
  wire         pin = doe ? dout : (poe ? pdata : float_ff);

  always #10 clock = ~clock;

  spe_engine dut (.CLOCK(clock), .RESET(reset), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PROG_CLOCK_PIN(pclk), .PROG_DATA_PIN_I(pin), .PROG_DATA_PIN_O(dout),
    .PROG_DATA_PIN_OE(doe), .EXEC(exec), .CPU_SUSPEND(cpu_suspend),
    .CPU_RESET_REQ(cpu_reset_req), .FLASH(flash));
  spe_prog_model prog (.clock(clock), .pclk(pclk), .pdata(pdata), .poe(poe), .pin(pin));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Counters, contention, hang limit
  always @(posedge clock)
  begin
    float_ff <= ~float_ff;
    cycles++;
    if (exec.valid === 1'h1)
    begin
      valid_seen++;
      last_instr = exec.instr;
    end
    if (cpu_reset_req === 1'h1)
      req_seen++;
    if (doe === 1'h1 && poe === 1'h1)
      check("contention", 32'h1, 32'h0);
    if (cycles > 20000)
    begin
      bad_count++;
      test_done;
    end
  end

  // Held until waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0)
      @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
    @(posedge clock);
  endtask

  task automatic code(input logic [3:0] c);
    prog.xfer({20'h0, c}, 4, 1'h1, got);
  endtask

  // Bounded wait for n words
  task automatic wait_valid(input int n);
    for (int i = 0; i < 20 && valid_seen < n; i++)
      @(posedge clock);
  endtask

  task automatic t_regs;
    bus(1'h0, SPE_OFS_MEM_CTRL, 32'h0);
    check("mem_ctrl", rd, 32'(SPE_MC_RESET));
    bus(1'h0, SPE_OFS_PROG_COUNTER, 32'h0);
    check("pc", rd, 32'(SPE_PC_SAFE));
    bus(1'h1, 6'h18, 32'hFFFFFFFF); // Unmapped hole ignores writes
    bus(1'h0, 6'h18, 32'h0);
    check("hole", rd, 32'h0);
    $display("t_regs done");
  endtask

  // Split word, then overlapped code
  task automatic t_six;
    int v0;
    v0 = valid_seen;
    code(SPE_CODE_SERIAL_EXECUTE);
    prog.xfer(24'h8C3A51, 12, 1'h1, got);
    check("suspend", 32'(cpu_suspend), 32'h1);
    check("early", 32'(valid_seen), 32'(v0));
    prog.xfer(24'h0008C3, 12, 1'h1, got);
    wait_valid(v0 + 1);
    check("instr", 32'(last_instr), 32'h8C3A51);
    prog.xfer(24'h0, 3, 1'h1, got);
    check("running", 32'(exec.running), 32'h1);
    prog.xfer(24'h0, 1, 1'h1, got);
    check("running", 32'(exec.running), 32'h0);
    prog.xfer(24'h5A5A5A, 24, 1'h1, got);
    wait_valid(v0 + 2);
    check("instr", 32'(last_instr), 32'h5A5A5A);
    bus(1'h0, SPE_OFS_PROG_COUNTER, 32'h0);
    check("pc", rd, 32'(SPE_PC_SAFE + SPE_PC_STEP + SPE_PC_STEP));
    $display("t_six done");
  endtask

  task automatic t_register_shift_out_code;
    bus(1'h1, SPE_OFS_VISIBLE_OUT, 32'h0000B4E1);
    code(SPE_CODE_REG_SHIFT_OUT);
    prog.xfer(24'h0, 7, 1'h1, got);
    check("idle", 32'({cpu_suspend, doe}), 32'h2);
    prog.xfer(24'h0, 1, 1'h1, got);
    prog.xfer(24'h0, 16, 1'h0, got);
    check("shift_out", 32'(got[15:0]), 32'h0000B4E1);
    check("hold", 32'(doe), 32'h1);
    prog.xfer(24'h0, 1, 1'h0, got);
    check("release", 32'(doe), 32'h0);
    $display("t_register_shift_out_code done");
  endtask

  // Reserved codes stay in the code wait
  task automatic t_reserved;
    int v0;
    v0 = valid_seen;
    for (int c = 2; c < 16; c++)
    begin
      code(4'(c));
      bus(1'h0, SPE_OFS_STATUS, 32'h0);
      check("state", 32'(rd[4:0]), 32'(SPE_ST_CODE));
    end
    code(SPE_CODE_SERIAL_EXECUTE);
    prog.xfer(24'h123456, 24, 1'h1, got);
    wait_valid(v0 + 1);
    check("valid_count", 32'(valid_seen), 32'(v0 + 1));
    $display("t_reserved done");
  endtask

  // Stepping past flash top resets core
  task automatic t_pc;
    int r0;
    r0 = req_seen;
    bus(1'h1, SPE_OFS_PROG_COUNTER, 32'(SPE_PC_FLASH_TOP));
    code(SPE_CODE_SERIAL_EXECUTE);
    prog.xfer(24'h0, 24, 1'h1, got);
    for (int i = 0; i < 20 && req_seen == r0; i++)
      @(posedge clock);
    check("core_reset", 32'(req_seen), 32'(r0 + 1));
    bus(1'h1, SPE_OFS_PROG_COUNTER, 32'(SPE_PC_SAFE));
    $display("t_pc done");
  endtask

  // Bad key refused, then each operation
  task automatic t_flash;
    logic [15:0] ops [3] = '{SPE_OP_BULK_ERASE, SPE_OP_PAGE_ERASE, SPE_OP_DWORD_PROGRAM};
    int          lens [3] = '{SPE_BULK_ERASE_CYC, SPE_PAGE_ERASE_CYC, SPE_DWORD_PROG_CYC};
    logic [31:0] exp;
    bus(1'h1, SPE_OFS_UNLOCK_KEY, 32'(SPE_KEY_SECOND));
    bus(1'h1, SPE_OFS_UNLOCK_KEY, 32'(SPE_KEY_FIRST));
    bus(1'h1, SPE_OFS_MEM_CTRL, 32'h0000C001);
    bus(1'h0, SPE_OFS_MEM_CTRL, 32'h0);
    check("refused", 32'({flash.busy, rd[15], rd[13]}), 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'h1, SPE_OFS_UNLOCK_KEY, 32'(SPE_KEY_FIRST));
      bus(1'h1, SPE_OFS_UNLOCK_KEY, 32'(SPE_KEY_SECOND));
      bus(1'h1, SPE_OFS_MEM_CTRL, 32'({1'h1, ops[k][14:0]}));
      bus(1'h0, SPE_OFS_MEM_CTRL, 32'h0);
      exp = {25'h0, 1'h1, ops[k][3:0], 2'h2};
      check("started", 32'({flash.busy, flash.op, rd[15], rd[13]}), exp);
      prog.xfer(24'h0, lens[k] - 1, 1'h1, got); // Zero frames are no-ops
      check("op_busy", 32'(flash.busy), 32'h1);
      prog.xfer(24'h0, 1, 1'h1, got);
      bus(1'h0, SPE_OFS_MEM_CTRL, 32'h0);
      check("op_done", 32'({flash.busy, rd[15]}), 32'h0);
    end
    prog.xfer(24'h0, 16, 1'h1, got); // Close the last no-op frame
    $display("t_flash done");
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_regs;
    t_six;
    t_register_shift_out_code;
    t_reserved;
    t_pc;
    t_flash;
    test_done;
  end
endmodule
`default_nettype wire
